// [eiu_ext_irq.sv]
/*
 * External interrupt and wake-up line unit: eight channels with mask,
 * pair priority, edge select and pending; top-level source; nested hold
 * levels; code segment stacking option; 16 wake lines and stop sequence.
 * Assumes an APB master on pclk, pins synchronous to pclk, and a CPU
 * that pulses cpu_ack for one cycle while irq_req is high and cpu_iret
 * once per return.
 */
// The APB slave port was left to the implementer.
// Contract
// - Channel mask bit 0 blocks; 1 requests when pending and global enable set.
// - Priority is pair field plus fixed low bit: 0 even, 1 odd channel.
// - Priority 0 highest, 7 lowest; priority fields reset to all ones.
// - Vector upper nibble from software, not reset; low bits name channel.
// - Non-maskable input edge: 0 falling, 1 rising.
// - Top source select: 0 watchdog end of count, 1 non-maskable pin.
// - Channel A0 source: 0 watchdog end of count, 1 external pin.
// - Wait enable 0 ignores wait pin; 1 lets it stretch memory cycles.
// - Top unmaskable bit set-only; when set top needs only pending.
// - Nested mode: hold bit set on preemption, cleared on resuming return.
// - Stacking bit clear: push PC and flags; segment register serves.
// - Stacking bit set: push old code segment too; return restores it.
// - Group select: last channel from dedicated pin or from 16 wake lines.
// - Wake mode bit: clear plain interrupt, set allows stop exit.
// - Each wake line has its own mask and trigger edge.
// - Unmasked wake lines in wake mode end stop mode.
// - Stop needs writes 1, 0, 1 to the stop bit, consecutively.
// - Pending set by trigger, cleared by acknowledge, settable by software.
// - Channel edge bit: 0 falling, 1 rising.
// - Stop succeeds only in wake mode, no unmasked pending, some unmasked.
`timescale 1ns/1ps
`default_nettype none
`include "eiu_regs.svh"

module eiu_ext_irq #(
    parameter int NCH = 8,
    parameter int NWAKE = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] ext_irq_pins,
    input wire logic dedicated_irq_pin,
    input wire logic nmi_pin,
    input wire logic wdog_end_count,
    input wire logic mem_wait_pin,
    input wire logic [NWAKE-1:0] wake_pins,
    input wire logic cpu_ack,
    input wire logic cpu_iret,
    output logic irq_req,
    output logic irq_top,
    output logic [7:0] irq_vector,
    output logic [2:0] irq_level,
    output logic mem_wait,
    output logic stop_req,
    output logic push_code_seg,
    output logic irq_seg_as_code
);

    // Channel index is three bits wide and the wake registers are one word
    if (NCH != 8 || NWAKE < 1 || NWAKE > 16)
    begin : g_bad_params
        $error("eiu_ext_irq: NCH must be 8 and NWAKE 1 to 16");
    end

    logic [7:0] cc_q, edge_q, pend_q, pend_d, mask_q, prio_q, nest_q, ctl_q;
    logic [3:0] vec_hi_q;
    logic ss_en_q;
    logic [2:0] wctl_q;
    logic [NWAKE-1:0] wmask_q, wedge_q, wpend_q, wpend_d, wake_prev_q;
    logic [NCH-1:0] src_prev_q;
    logic [NCH-1:0] src;
    logic top_src_prev_q, top_active_q, stop_q, wake_or;
    logic [3:0] depth_q;
    logic [2:0] sel_q;
    logic [31:0] rdata;
    logic mapped;
    eiu_pkg::eiu_stop_seq_t seq_q;

    wire [9:0] idx = paddr[11:2];
    wire setup = psel && !penable;
    wire wr = psel && penable && pready && pwrite;
    wire ack_ch = cpu_ack && irq_req && !irq_top;
    wire ack_top = cpu_ack && irq_req && irq_top;
    wire [2:0] cpl = cc_q[2:0];
    wire global_irq_enable = cc_q[`EIU_CC_GLOBAL_EN];
    wire nested = cc_q[`EIU_CC_NESTED];
    localparam logic [7:0] SS_RST = `EIU_RST_SEG_STACK;
    localparam logic [7:0] SS_FIXED = `EIU_SEG_STACK_FIXED;

    function automatic logic edge_seen(input logic prev, input logic cur, input logic rise);
        edge_seen = rise ? (!prev && cur) : (prev && !cur);
    endfunction

    function automatic logic [2:0] chan_prio(input logic [7:0] pl, input int ch);
        chan_prio = {pl[(ch/2)*2+1], pl[(ch/2)*2], ch[0]};
    endfunction

    // Channel sources
    always_comb
    begin
        src = ext_irq_pins;
        src[0] = ctl_q[`EIU_VC_A0_SRC] ? ext_irq_pins[0] : wdog_end_count;
        src[`EIU_LAST_CHAN] = wctl_q[`EIU_WC_GROUP] ? wake_or : dedicated_irq_pin;
    end

    // The wake lines reach the channel as the OR of unmasked pending bits, so a
    // second event while one is pending gives no new edge until every unmasked pending bit clears.
    assign wake_or = |(wpend_q & wmask_q);

    wire top_src = ctl_q[`EIU_VC_TOP_SRC] ? nmi_pin : wdog_end_count;
    wire top_edge_rise = ctl_q[`EIU_VC_TOP_SRC] ? ctl_q[`EIU_VC_NMI_EDGE] : 1'b1;

    // Arbitration: lowest priority value below the current level wins
    logic found;
    logic [2:0] best_ch, best_pr;
    always_comb
    begin
        found = 1'b0;
        best_ch = 3'h0;
        best_pr = `EIU_CPL_LOWEST;
        for (int i = 0; i < NCH; i++)
        begin
            if (pend_q[i] && mask_q[i] && global_irq_enable
                && chan_prio(prio_q, i) < cpl
                && (!found || chan_prio(prio_q, i) < best_pr))
            begin
                found = 1'b1;
                best_ch = i[2:0];
                best_pr = chan_prio(prio_q, i);
            end
        end
    end

    wire top_ok = cc_q[`EIU_CC_TOP_PEND] && (nest_q[`EIU_NC_UNMASK]
        || (global_irq_enable && cc_q[`EIU_CC_TOP_EN]));
    // The top routine cannot be interrupted, not even by another top request
    wire want_top = top_ok && !top_active_q;
    wire want_ch = found && !top_active_q;

    // Request outputs; dropped in the acknowledge cycle so no stale request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_req <= 1'b0;
            irq_top <= 1'b0;
            irq_vector <= 8'h00;
            irq_level <= 3'h0;
            sel_q <= 3'h0;
        end
        else
        begin
            irq_req <= !cpu_ack && (want_top || want_ch);
            irq_top <= want_top;
            sel_q <= best_ch;
            irq_level <= want_top ? 3'h0 : best_pr;
            irq_vector <= {vec_hi_q, best_ch, 1'b0};
        end
    end

    // Channel pending: set wins over acknowledge and software clear
    always_comb
    begin
        pend_d = pend_q;
        if (wr && idx == `EIU_IDX_EXT_PEND)
            pend_d = pwdata[7:0];
        if (ack_ch)
            pend_d[sel_q] = 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
            if (edge_seen(src_prev_q[i], src[i], edge_q[i]))
                pend_d[i] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q <= 8'h00;
            src_prev_q <= '0;
            top_src_prev_q <= 1'b0;
        end
        else
        begin
            pend_q <= pend_d;
            src_prev_q <= src;
            top_src_prev_q <= top_src;
        end
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            edge_q <= 8'h00;
            mask_q <= 8'h00;
            prio_q <= `EIU_RST_PRIO;
            ctl_q <= {4'h0, `EIU_RST_VEC_LOW};
            ss_en_q <= SS_RST[`EIU_SS_ENABLE];
            wmask_q <= '0;
            wedge_q <= '0;
        end
        else if (wr)
        begin
            case (idx)
                `EIU_IDX_EXT_EDGE: edge_q <= pwdata[7:0];
                `EIU_IDX_EXT_MASK: mask_q <= pwdata[7:0];
                `EIU_IDX_EXT_PRIO: prio_q <= pwdata[7:0];
                `EIU_IDX_VEC_CTRL: ctl_q <= {4'h0, pwdata[3:0]};
                `EIU_IDX_SEG_STACK: ss_en_q <= pwdata[`EIU_SS_ENABLE];
                `EIU_IDX_WAKE_MASK: wmask_q <= pwdata[NWAKE-1:0];
                `EIU_IDX_WAKE_EDGE: wedge_q <= pwdata[NWAKE-1:0];
                default: ;
            endcase
        end
    end

    // Vector nibble keeps no reset value on purpose
    always_ff @(posedge pclk)
    begin
        if (wr && idx == `EIU_IDX_VEC_CTRL)
            vec_hi_q <= pwdata[7:4];
    end

    // Core control: enable, top pending, current level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cc_q <= `EIU_RST_CORE_CTRL;
        else
        begin
            if (wr && idx == `EIU_IDX_CORE_CTRL)
                cc_q <= {1'b0, pwdata[6:0]};
            if (ack_top)
                cc_q[`EIU_CC_TOP_PEND] <= 1'b0;
            if (ack_ch)
            begin
                cc_q[`EIU_CC_GLOBAL_EN] <= 1'b0;
                if (nested)
                    cc_q[2:0] <= irq_level;
            end
            if (cpu_iret && !top_active_q)
            begin
                cc_q[`EIU_CC_GLOBAL_EN] <= 1'b1;
                if (nested)
                    cc_q[2:0] <= resume_level(nest_q[6:0]);
            end
            if (edge_seen(top_src_prev_q, top_src, top_edge_rise))
                cc_q[`EIU_CC_TOP_PEND] <= 1'b1;
        end
    end

    function automatic logic [2:0] resume_level(input logic [6:0] hold);
        resume_level = `EIU_CPL_LOWEST;
        for (int i = 6; i >= 0; i--)
        begin
            if (hold[i])
                resume_level = i[2:0];
        end
    endfunction

    // Unmaskable flag and hold levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nest_q <= 8'h00;
        else
        begin
            if (wr && idx == `EIU_IDX_NEST_CTRL && pwdata[`EIU_NC_UNMASK])
                nest_q[`EIU_NC_UNMASK] <= 1'b1;
            if (ack_ch && nested && cpl != `EIU_CPL_LOWEST)
                nest_q[cpl] <= 1'b1;
            if (cpu_iret && !top_active_q && nested
                && resume_level(nest_q[6:0]) != `EIU_CPL_LOWEST)
                nest_q[resume_level(nest_q[6:0])] <= 1'b0;
        end
    end

    // Service depth and segment handling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            top_active_q <= 1'b0;
            depth_q <= 4'h0;
            push_code_seg <= 1'b0;
            irq_seg_as_code <= 1'b0;
        end
        else
        begin
            if (ack_top)
                top_active_q <= 1'b1;
            else if (cpu_iret)
                top_active_q <= 1'b0;
            if (cpu_ack && irq_req && depth_q != 4'hf)
            begin
                depth_q <= depth_q + 4'h1;
                push_code_seg <= ss_en_q;
                irq_seg_as_code <= !ss_en_q;
            end
            else if (cpu_iret && depth_q != 4'h0)
            begin
                depth_q <= depth_q - 4'h1;
                if (depth_q == 4'h1)
                    irq_seg_as_code <= 1'b0;
            end
        end
    end

    // Wait pin gating
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mem_wait <= 1'b0;
        else
            mem_wait <= ctl_q[`EIU_VC_WAIT_EN] && mem_wait_pin;
    end

    // Wake line pending: edge sets win over software writes
    always_comb
    begin
        wpend_d = wpend_q;
        if (wr && idx == `EIU_IDX_WAKE_PEND)
            wpend_d = pwdata[NWAKE-1:0];
        for (int i = 0; i < NWAKE; i++)
        begin
            if (edge_seen(wake_prev_q[i], wake_pins[i], wedge_q[i]))
                wpend_d[i] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wpend_q <= '0;
            wake_prev_q <= '0;
        end
        else
        begin
            wpend_q <= wpend_d;
            wake_prev_q <= wake_pins;
        end
    end

    // Stop sequence: any other register write or acknowledge breaks it
    wire wctl_wr = wr && idx == `EIU_IDX_WAKE_CTRL;
    wire stop_bit = pwdata[`EIU_WC_STOP];
    wire stop_ok = wctl_q[`EIU_WC_WAKE_MODE] && !(|(wpend_q & wmask_q))
        && (|wmask_q);
    wire wake_hit = |(wpend_d & ~wpend_q & wmask_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_q <= eiu_pkg::EIU_SEQ_IDLE;
            stop_q <= 1'b0;
            stop_req <= 1'b0;
            wctl_q <= 3'h0;
        end
        else
        begin
            stop_req <= stop_q && seq_q == eiu_pkg::EIU_SEQ_IDLE;
            if (wctl_wr)
                wctl_q[1:0] <= pwdata[1:0];
            if (wctl_wr)
            begin
                case (seq_q)
                    eiu_pkg::EIU_SEQ_IDLE:
                    begin
                        seq_q <= stop_bit ? eiu_pkg::EIU_SEQ_ONE : eiu_pkg::EIU_SEQ_IDLE;
                        stop_q <= stop_bit;
                    end
                    eiu_pkg::EIU_SEQ_ONE:
                    begin
                        seq_q <= stop_bit ? eiu_pkg::EIU_SEQ_ONE : eiu_pkg::EIU_SEQ_ONE_ZERO;
                        stop_q <= stop_bit;
                    end
                    eiu_pkg::EIU_SEQ_ONE_ZERO:
                    begin
                        seq_q <= eiu_pkg::EIU_SEQ_IDLE;
                        stop_q <= stop_bit && stop_ok;
                    end
                    default:
                    begin
                        seq_q <= eiu_pkg::EIU_SEQ_IDLE;
                        stop_q <= 1'b0;
                    end
                endcase
            end
            else if (wr || cpu_ack)
            begin
                seq_q <= eiu_pkg::EIU_SEQ_IDLE;
                stop_q <= 1'b0;
            end
            else if (seq_q == eiu_pkg::EIU_SEQ_IDLE && stop_q && wake_hit)
                stop_q <= 1'b0;
        end
    end

    // APB read data captured in the setup cycle; one access cycle, no waits
    always_comb
    begin
        rdata = 32'h0000_0000;
        mapped = 1'b1;
        case (idx)
            `EIU_IDX_CORE_CTRL: rdata[7:0] = cc_q;
            `EIU_IDX_EXT_EDGE: rdata[7:0] = edge_q;
            `EIU_IDX_EXT_PEND: rdata[7:0] = pend_q;
            `EIU_IDX_EXT_MASK: rdata[7:0] = mask_q;
            `EIU_IDX_EXT_PRIO: rdata[7:0] = prio_q;
            `EIU_IDX_VEC_CTRL: rdata[7:0] = {vec_hi_q, ctl_q[3:0]};
            `EIU_IDX_NEST_CTRL: rdata[7:0] = nest_q;
            `EIU_IDX_SEG_STACK: rdata[7:0] = {1'b0, ss_en_q, SS_FIXED[5:0]};
            `EIU_IDX_WAKE_CTRL: rdata[7:0] = {5'h00, stop_q, wctl_q[1:0]};
            `EIU_IDX_WAKE_MASK: rdata[NWAKE-1:0] = wmask_q;
            `EIU_IDX_WAKE_EDGE: rdata[NWAKE-1:0] = wedge_q;
            `EIU_IDX_WAKE_PEND: rdata[NWAKE-1:0] = wpend_q;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup)
                prdata <= pwrite ? 32'h0000_0000 : rdata;
        end
    end

    // Checks
    a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        irq_req && !irq_top |-> mask_q[sel_q] && pend_q[sel_q] && global_irq_enable)
        else $error("channel request without mask, pending or enable");
    a_prio_lsb: assert property (@(posedge pclk) disable iff (!presetn)
        irq_req && !irq_top |-> irq_level[0] == sel_q[0] && irq_level != 3'h7)
        else $error("channel priority low bit wrong");
    a_prio_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> prio_q == `EIU_RST_PRIO)
        else $error("priority fields not all ones after reset");
    a_vector_form: assert property (@(posedge pclk) disable iff (!presetn)
        irq_req && !irq_top |-> irq_vector[3:0] == {sel_q, 1'b0})
        else $error("vector low bits do not name channel");
    a_unmask_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        nest_q[`EIU_NC_UNMASK] |=> nest_q[`EIU_NC_UNMASK])
        else $error("unmaskable flag cleared without reset");
    a_hold_set: assert property (@(posedge pclk) disable iff (!presetn)
        ack_ch && nested && cpl != 3'h7 |=> nest_q[$past(cpl)])
        else $error("hold level not set on preemption");
    a_pend_ack: assert property (@(posedge pclk) disable iff (!presetn)
        ack_ch && !edge_seen(src_prev_q[sel_q], src[sel_q], edge_q[sel_q])
        && !wr |=> !pend_q[$past(sel_q)] ##1 !irq_req [*1])
        else $error("pending bit survived acknowledge");
    a_wait_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_q[`EIU_VC_WAIT_EN] |=> !mem_wait)
        else $error("wait passed while disabled");
    a_stop_cond: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(stop_req) |-> $past(wctl_q[`EIU_WC_WAKE_MODE], 2) && |wmask_q)
        else $error("stop requested without conditions");
    a_seg_mode: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_ack && irq_req && depth_q != 4'hf
        |=> push_code_seg == $past(ss_en_q) && irq_seg_as_code != $past(ss_en_q))
        else $error("segment stacking outputs disagree");

    c_chan_ack: cover property (@(posedge pclk) disable iff (!presetn) ack_ch);
    c_top_ack: cover property (@(posedge pclk) disable iff (!presetn) ack_top);
    c_stop: cover property (@(posedge pclk) disable iff (!presetn) $rose(stop_req));
    c_nested: cover property (@(posedge pclk) disable iff (!presetn) ack_ch && nested
        && cpl != 3'h7);

endmodule // eiu_ext_irq

`default_nettype wire

// [eiu_regs.svh]
/*
 * Register indices, field positions and reset values of the
 * external interrupt and wake-up unit.
 * Assumes the includer maps each index to byte address index * 4.
 */
`ifndef EIU_REGS_SVH
`define EIU_REGS_SVH

// Register indices (byte address is four times the index)
`define EIU_IDX_CORE_CTRL 10'h0e6
`define EIU_IDX_EXT_EDGE 10'h0f2
`define EIU_IDX_EXT_PEND 10'h0f3
`define EIU_IDX_EXT_MASK 10'h0f4
`define EIU_IDX_EXT_PRIO 10'h0f5
`define EIU_IDX_VEC_CTRL 10'h0f6
`define EIU_IDX_NEST_CTRL 10'h0f7
`define EIU_IDX_SEG_STACK 10'h1f6
`define EIU_IDX_WAKE_CTRL 10'h1f9
`define EIU_IDX_WAKE_MASK 10'h1fa
`define EIU_IDX_WAKE_EDGE 10'h1fb
`define EIU_IDX_WAKE_PEND 10'h1fc

// Reset values
`define EIU_RST_CORE_CTRL 8'h07
`define EIU_RST_PRIO 8'hff
`define EIU_RST_VEC_LOW 4'h6
`define EIU_RST_SEG_STACK 8'h0f
`define EIU_SEG_STACK_FIXED 8'h0f

// Core control fields
`define EIU_CC_TOP_PEND 6
`define EIU_CC_TOP_EN 5
`define EIU_CC_GLOBAL_EN 4
`define EIU_CC_NESTED 3
`define EIU_CPL_LOWEST 3'h7

// Vector control fields
`define EIU_VC_NMI_EDGE 3
`define EIU_VC_TOP_SRC 2
`define EIU_VC_A0_SRC 1
`define EIU_VC_WAIT_EN 0

// Nested control and segment stack fields
`define EIU_NC_UNMASK 7
`define EIU_SS_ENABLE 6

// Wake control fields
`define EIU_WC_STOP 2
`define EIU_WC_GROUP 1
`define EIU_WC_WAKE_MODE 0

// Channel that the wake lines may drive
`define EIU_LAST_CHAN 7

`endif

// [eiu_pkg.sv]
/*
 * Types shared by the external interrupt and wake-up unit.
 * Assumes nothing of its surroundings.
 */
package eiu_pkg;
    typedef enum logic [1:0] {
        EIU_SEQ_IDLE,
        EIU_SEQ_ONE,
        EIU_SEQ_ONE_ZERO
    } eiu_stop_seq_t;
endpackage

// [eiu_pin_model.sv]
/* Pin-side model: channel, NMI, wait and wake lines of the interrupt unit.
   Assumes its task is called just after a rising pclk edge. */
`timescale 1ns/1ps
`default_nettype none
module eiu_pin_model (
    input wire logic pclk,
    output logic [7:0] ext_irq_pins,
    output logic dedicated_irq_pin,
    output logic nmi_pin,
    output logic mem_wait_pin,
    output logic [15:0] wake_pins
);
    initial
    begin
        ext_irq_pins = 8'h00;
        dedicated_irq_pin = 1'b0;
        nmi_pin = 1'b0;
        mem_wait_pin = 1'b0;
        wake_pins = 16'h0000;
    end
    // 0..7 channel lines (7 is the dedicated pin), 8 NMI, 9 wait, 10+ wake
    // Held two edges so that a single-cycle edge detector cannot miss it
    task automatic drive(input int sel, input logic v);
        if (sel < 8)
            ext_irq_pins[sel] <= v;
        if (sel == 7)
            dedicated_irq_pin <= v;
        if (sel == 8)
            nmi_pin <= v;
        if (sel == 9)
            mem_wait_pin <= v;
        if (sel >= 10)
            wake_pins[sel-10] <= v;
        repeat (2) @(posedge pclk);
    endtask
endmodule // eiu_pin_model
`default_nettype wire

// [tb_top.sv]
/* Self-checking bench for the interrupt unit, APB master and CPU side.
   Assumes the pin model answers for the pin side. */
`timescale 1ns/1ps
`default_nettype none
`include "eiu_regs.svh"
module tb_top;
    localparam logic [7:0] PRIO = 8'h24;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic cpu_ack = 1'b0;
    logic cpu_iret = 1'b0;
    logic wdog_end_count = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, irq_req, irq_top, mem_wait, stop_req;
    logic push_code_seg, irq_seg_as_code, irq_d;
    logic [2:0] irq_level;
    logic [7:0] irq_vector, ext_irq_pins, e, r;
    logic dedicated_irq_pin, nmi_pin, mem_wait_pin;
    logic [15:0] wake_pins;
    logic [3:0] nib;
    logic [32:0] rd_q[$];
    logic [11:0] irq_q[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    eiu_ext_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pins(ext_irq_pins), .dedicated_irq_pin(dedicated_irq_pin),
        .nmi_pin(nmi_pin), .wdog_end_count(wdog_end_count), .mem_wait_pin(mem_wait_pin),
        .wake_pins(wake_pins), .cpu_ack(cpu_ack), .cpu_iret(cpu_iret), .irq_req(irq_req),
        .irq_top(irq_top), .irq_vector(irq_vector), .irq_level(irq_level),
        .mem_wait(mem_wait), .stop_req(stop_req), .push_code_seg(push_code_seg),
        .irq_seg_as_code(irq_seg_as_code));
    eiu_pin_model u_pins (.pclk(pclk), .ext_irq_pins(ext_irq_pins),
        .dedicated_irq_pin(dedicated_irq_pin), .nmi_pin(nmi_pin),
        .mem_wait_pin(mem_wait_pin), .wake_pins(wake_pins));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [32:0] x);
        rd_q.push_back(x);
        apb(1'b0, idx, 32'h0);
    endtask
    task automatic service(input logic pc);
        while (irq_req !== 1'b1)
            @(posedge pclk);
        cpu_ack <= 1'b1;
        @(posedge pclk);
        cpu_ack <= 1'b0;
        @(posedge pclk);
        chk({irq_req, push_code_seg, irq_seg_as_code}, {1'b0, pc, ~pc});
        cpu_iret <= 1'b1;
        @(posedge pclk);
        cpu_iret <= 1'b0;
        @(posedge pclk);
    endtask
    // Results are taken off the queues in the order they were noted
    always @(posedge pclk)
    begin
        cyc++;
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, rd_q.pop_front());
        if (irq_req === 1'b1 && irq_d !== 1'b1)
            chk({irq_top, irq_level, irq_top ? 8'h00 : irq_vector},
                irq_q.size() > 0 ? irq_q.pop_front() : 33'h1ffffffff);
        irq_d <= irq_req;
        if (cyc == 30000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        void'($urandom(32'h40cd));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`EIU_IDX_EXT_MASK, 33'h00);
        rd(`EIU_IDX_EXT_PRIO, 33'hff);
        rd(`EIU_IDX_SEG_STACK, 33'h0f);
        rd(`EIU_IDX_NEST_CTRL, 33'h00);
        rd(10'h000, 33'h100000000);
        r = 8'($urandom);
        nib = 4'($urandom);
        e = 8'($urandom);
        wr(`EIU_IDX_EXT_MASK, {24'h0, r});
        rd(`EIU_IDX_EXT_MASK, {25'h0, r});
        for (int ch = 0; ch < 8; ch++)
            u_pins.drive(ch, ~e[ch]);
        wr(`EIU_IDX_EXT_PRIO, {24'h0, PRIO});
        wr(`EIU_IDX_VEC_CTRL, {24'h0, nib, 4'h2});
        wr(`EIU_IDX_EXT_EDGE, {24'h0, e});
        wr(`EIU_IDX_EXT_MASK, 32'hff);
        for (int ch = 0; ch < 8; ch++)
        begin
            if (ch == 7)
            begin
                wr(`EIU_IDX_SEG_STACK, 32'h4f);
                rd(`EIU_IDX_SEG_STACK, 33'h4f);
            end
            wr(`EIU_IDX_CORE_CTRL, 32'h17);
            irq_q.push_back({1'b0, PRIO[2*(ch/2) +: 2], ch[0], nib, 3'(ch), 1'b0});
            u_pins.drive(ch, e[ch]);
            service(ch == 7);
            u_pins.drive(ch, ~e[ch]);
            rd(`EIU_IDX_EXT_PEND, 33'h0);
        end
        wr(`EIU_IDX_EXT_MASK, 32'h0);
        wr(`EIU_IDX_CORE_CTRL, 32'h17);
        u_pins.drive(3, e[3]);
        repeat (3) @(posedge pclk);
        chk(irq_req, 1'b0);
        rd(`EIU_IDX_EXT_PEND, 33'h08);
        u_pins.drive(3, ~e[3]);
        u_pins.drive(7, 1'b0);
        wr(`EIU_IDX_EXT_EDGE, 32'h80);
        wr(`EIU_IDX_EXT_PEND, 32'h0);
        wr(`EIU_IDX_VEC_CTRL, {24'h0, nib, 4'h3});
        u_pins.drive(9, 1'b1);
        chk(mem_wait, 1'b1);
        wr(`EIU_IDX_VEC_CTRL, {24'h0, nib, 4'h2});
        repeat (2) @(posedge pclk);
        chk(mem_wait, 1'b0);
        wr(`EIU_IDX_WAKE_EDGE, 32'hffff);
        wr(`EIU_IDX_WAKE_MASK, 32'h1);
        wr(`EIU_IDX_WAKE_PEND, 32'h0);
        wr(`EIU_IDX_WAKE_CTRL, 32'h2);
        wr(`EIU_IDX_EXT_MASK, 32'h80);
        for (int i = 0; i < 3; i++)
            wr(`EIU_IDX_WAKE_CTRL, (i == 1) ? 32'h2 : 32'h6);
        rd(`EIU_IDX_WAKE_CTRL, 33'h2);
        chk(stop_req, 1'b0);
        for (int i = 0; i < 3; i++)
            wr(`EIU_IDX_WAKE_CTRL, (i == 1) ? 32'h3 : 32'h7);
        rd(`EIU_IDX_WAKE_CTRL, 33'h7);
        @(posedge pclk);
        chk(stop_req, 1'b1);
        irq_q.push_back({1'b0, 3'd1, nib, 3'd7, 1'b0});
        u_pins.drive(10, 1'b1);
        service(1'b1);
        chk(stop_req, 1'b0);
        rd(`EIU_IDX_WAKE_PEND, 33'h1);
        rd(`EIU_IDX_WAKE_CTRL, 33'h3);
        wr(`EIU_IDX_VEC_CTRL, {24'h0, nib, 4'he});
        wr(`EIU_IDX_NEST_CTRL, 32'h80);
        wr(`EIU_IDX_CORE_CTRL, 32'h07);
        irq_q.push_back(12'h800);
        u_pins.drive(8, 1'b1);
        service(1'b1);
        wr(`EIU_IDX_NEST_CTRL, 32'h0);
        rd(`EIU_IDX_NEST_CTRL, 33'h80);
        // Nested: channel 3 in service at level 3 is preempted by channel 0
        wr(`EIU_IDX_EXT_EDGE, {24'h0, e});
        wr(`EIU_IDX_EXT_MASK, 32'h09);
        wr(`EIU_IDX_CORE_CTRL, 32'h1f);
        irq_q.push_back({1'b0, 3'd3, nib, 3'd3, 1'b0});
        u_pins.drive(3, e[3]);
        while (irq_req !== 1'b1)
            @(posedge pclk);
        cpu_ack <= 1'b1;
        @(posedge pclk);
        cpu_ack <= 1'b0;
        wr(`EIU_IDX_CORE_CTRL, 32'h1b);
        irq_q.push_back({1'b0, 3'd0, nib, 3'd0, 1'b0});
        u_pins.drive(0, e[0]);
        service(1'b1);
        rd(`EIU_IDX_CORE_CTRL, 33'h1b);
        rd(`EIU_IDX_NEST_CTRL, 33'h80);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
